// File: shared/sesreq_defs.svh
// Purpose: timing figures and reset values for the session request control block
// Assumes: one 25 MHz clock; times held in microseconds, counts derived in the top module
// Notes:   guarded, definitions only
`ifndef SESREQ_DEFS_SVH
`define SESREQ_DEFS_SVH

`define SESREQ_CLK_MHZ        25
`define SESREQ_SE0_MIN_US     2000
`define SESREQ_DPLS_MIN_US    5000
`define SESREQ_DPLS_MAX_US    10000
`define SESREQ_DPLS_US        7500
`define SESREQ_DISCH_MAX_US   100000
`define SESREQ_VPLS_US        5000
`define SESREQ_SYNC_RST       6'h00
`define SESREQ_SYNC_W         6
`define SESREQ_SYNC_ISA       0
`define SESREQ_SYNC_DP        1
`define SESREQ_SYNC_DM        2
`define SESREQ_SYNC_AVLD      3
`define SESREQ_SYNC_BVLD      4
`define SESREQ_SYNC_VEND      5

`endif

// File: shared/sesreq_pkg.sv
// Purpose: types shared by the session request control modules
// Assumes: nothing beyond the defs header
// Notes:   state codes left to the tools
package sesreq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DISCH,
    ST_WAIT_SE0,
    ST_DPULSE,
    ST_VPULSE
  } sesreq_state_t;
endpackage

// File: shared/sesreq_tmr_if.sv
// Purpose: carrier between the controller and its line-idle timer
// Assumes: same clock on both ends
// Notes:   restart is a level, done is a registered level
`timescale 1ns/100ps
interface sesreq_tmr_if;
  logic restart;
  logic done;
  modport ctl (output restart, input done);
  modport tmr (input restart, output done);
endinterface // sesreq_tmr_if

// File: logic/sesreq_timer.sv
// Purpose: saturating interval timer, done once restart has stayed low LIMIT cycles
// Assumes: restart already synchronised to clk
// Notes:   done drops on the edge after any restart
`timescale 1ns/100ps
`include "sesreq_defs.svh"
module sesreq_timer import sesreq_pkg::*; #(
  parameter int LIMIT = 50000
) (
  input  wire logic     clk,
  input  wire logic     srst,
  sesreq_tmr_if.tmr     tif
);
  localparam int W = $clog2(LIMIT + 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         done_q;
  logic         next_done;

  // count up while lines idle, hold at the limit so a long idle never wraps
  always_comb begin
    next_cnt  = cnt;
    next_done = done_q;
    if (tif.restart) begin
      next_cnt  = '0;
      next_done = 1'b0;
    end else if (cnt != W'(LIMIT)) begin
      next_cnt  = cnt + W'(1);
      next_done = (cnt == W'(LIMIT - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt    <= '0;
      done_q <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      done_q <= next_done;
    end
  end

  assign tif.done = done_q;

  a_restart_clears: assert property (@(posedge clk) disable iff (srst)
    tif.restart |=> !tif.done) else $error("timer done right after restart");
  a_done_needs_idle: assert property (@(posedge clk) disable iff (srst)
    $rose(tif.done) |-> cnt == W'(LIMIT) && !$past(tif.restart))
    else $error("timer done without full idle count");
endmodule // sesreq_timer

// File: logic/sesreq_ctrl.sv
// Purpose: session tracking, session request origination and answer, line pull control
// Assumes: comparators and line receivers are asynchronous pins; control inputs share clk
// Notes:   long counts are parameters so a simulation can shorten them
`timescale 1ns/100ps
`include "sesreq_defs.svh"
module sesreq_ctrl import sesreq_pkg::*; #(
  parameter int SE0_CYC   = `SESREQ_SE0_MIN_US * `SESREQ_CLK_MHZ,
  parameter int DPLS_CYC  = `SESREQ_DPLS_US * `SESREQ_CLK_MHZ,
  parameter int DPLS_MIN  = `SESREQ_DPLS_MIN_US * `SESREQ_CLK_MHZ,
  parameter int DPLS_MAX  = `SESREQ_DPLS_MAX_US * `SESREQ_CLK_MHZ,
  parameter int DISCH_CYC = `SESREQ_DISCH_MAX_US * `SESREQ_CLK_MHZ,
  parameter int VPLS_CYC  = `SESREQ_VPLS_US * `SESREQ_CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic id_a_side,         // pin: high when plugged as A-device
  input  wire logic dp_line,           // pin: D+ receiver
  input  wire logic dm_line,           // pin: D- receiver
  input  wire logic a_sess_valid_cmp,  // pin: VBUS above a_side_session_valid_threshold
  input  wire logic b_sess_valid_cmp,  // pin: VBUS above b_side_session_valid_threshold
  input  wire logic b_sess_end_cmp,    // pin: VBUS below b_side_session_end_threshold
  input  wire logic request_start,     // pulse: software asks for a session
  input  wire logic use_discharge,     // level: switch in the discharge path first
  input  wire logic timed_discharge,   // level: trust discharge timeout, not comparator
  input  wire logic a_vbus_on,         // level: this device drives VBUS as A
  input  wire logic role_swap,         // pulse: host role changes hands
  input  wire logic packet_tx,         // level: packet being transmitted
  output logic      session_active,
  output logic      host_role,
  output logic      request_busy,
  output logic      request_done,
  output logic      request_seen,
  output logic      dp_pulldown_en,
  output logic      dm_pulldown_en,
  output logic      dp_pullup_en,
  output logic      vbus_drive_en,
  output logic      vbus_discharge_en
);
  localparam int CW = $clog2(DISCH_CYC + DPLS_CYC + VPLS_CYC + 1);

  logic [`SESREQ_SYNC_W-1:0] sync1;
  logic [`SESREQ_SYNC_W-1:0] sync2;
  logic [`SESREQ_SYNC_W-1:0] prev;
  logic          is_a, dp_s, dm_s, avld_s, bvld_s, vend_s;
  sesreq_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic          vlow_timed, next_vlow_timed;
  logic          vbus_low;
  logic          next_session, next_host, next_busy, next_done, next_seen;
  logic          next_pd_dp, next_pd_dm, next_pu_dp, next_vdrv, next_vdis;
  logic          periph;
  sesreq_tmr_if  se0_tif ();

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= `SESREQ_SYNC_RST;
      sync2 <= `SESREQ_SYNC_RST;
      prev  <= `SESREQ_SYNC_RST;
    end else begin
      sync1 <= {b_sess_end_cmp, b_sess_valid_cmp, a_sess_valid_cmp,
                dm_line, dp_line, id_a_side};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign is_a   = sync2[`SESREQ_SYNC_ISA];
  assign dp_s   = sync2[`SESREQ_SYNC_DP];
  assign dm_s   = sync2[`SESREQ_SYNC_DM];
  assign avld_s = sync2[`SESREQ_SYNC_AVLD];
  assign bvld_s = sync2[`SESREQ_SYNC_BVLD];
  assign vend_s = sync2[`SESREQ_SYNC_VEND];

  // se0 interval: any high line restarts the count
  assign se0_tif.restart = dp_s | dm_s;
  sesreq_timer #(.LIMIT(SE0_CYC)) u_se0 (
    .clk  (clk),
    .srst (srst),
    .tif  (se0_tif)
  );

  // a timed discharge stands in for the comparator when the comparator is not trusted
  assign vbus_low = timed_discharge ? vlow_timed : vend_s;

  // request sequencer: optional discharge, idle check, data-line pulse, vbus pulse
  always_comb begin
    next_state      = state;
    next_cnt        = cnt + CW'(1);
    next_vlow_timed = vlow_timed;
    next_done       = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_cnt = '0;
        if (request_start && !is_a && !session_active) begin
          next_vlow_timed = 1'b0;
          next_state = (use_discharge || timed_discharge) ? ST_DISCH : ST_WAIT_SE0;
        end
      end
      ST_DISCH: begin
        if (cnt == CW'(DISCH_CYC - 1)) begin
          next_vlow_timed = 1'b1;
          next_state      = ST_WAIT_SE0;
        end else if (!timed_discharge && vend_s) begin
          next_state = ST_WAIT_SE0;
        end
      end
      ST_WAIT_SE0: begin
        next_cnt = '0;
        if (session_active) begin
          next_state = ST_IDLE; // a session came up anyway, nothing to ask for
        end else if (vbus_low && se0_tif.done && !se0_tif.restart) begin
          next_state = ST_DPULSE;
        end
      end
      ST_DPULSE: begin
        if (cnt == CW'(DPLS_CYC - 1)) begin
          next_cnt   = '0;
          next_state = ST_VPULSE;
        end
      end
      ST_VPULSE: begin
        if (cnt == CW'(VPLS_CYC - 1)) begin
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // session, role and answer to a request when acting as A
  always_comb begin
    next_session = is_a ? avld_s : bvld_s;
    if (!next_session) begin
      next_host = 1'b0;
    end else if (!session_active) begin
      next_host = is_a;
    end else begin
      next_host = role_swap ? !host_role : host_role;
    end
    // either method is caught, so any partner request gets through
    next_seen = is_a && !a_vbus_on && !session_active &&
                ((dp_s && !prev[`SESREQ_SYNC_DP]) || (dm_s && !prev[`SESREQ_SYNC_DM]) ||
                 (avld_s && !prev[`SESREQ_SYNC_AVLD]));
    next_busy = (next_state != ST_IDLE);
  end

  // line terminations follow the role the next state will hold
  always_comb begin
    periph = next_session && !next_host;
    next_vdrv = (next_state == ST_VPULSE);
    next_vdis = (next_state == ST_DISCH);
    if (packet_tx && next_session) begin
      next_pd_dp = 1'b0;
      next_pd_dm = 1'b0;
      next_pu_dp = 1'b0;
    end else if (periph || next_state == ST_DPULSE) begin
      next_pd_dp = 1'b0;
      next_pd_dm = 1'b1;
      next_pu_dp = 1'b1;
    end else begin
      next_pd_dp = 1'b1;
      next_pd_dm = 1'b1;
      next_pu_dp = 1'b0;
    end
  end

  // every output is a flop, so nothing glitches onto the resistor switches
  always_ff @(posedge clk) begin
    if (srst) begin
      state             <= ST_IDLE;
      cnt               <= '0;
      vlow_timed        <= 1'b0;
      session_active    <= 1'b0;
      host_role         <= 1'b0;
      request_busy      <= 1'b0;
      request_done      <= 1'b0;
      request_seen      <= 1'b0;
      dp_pulldown_en    <= 1'b1;
      dm_pulldown_en    <= 1'b1;
      dp_pullup_en      <= 1'b0;
      vbus_drive_en     <= 1'b0;
      vbus_discharge_en <= 1'b0;
    end else begin
      state             <= next_state;
      cnt               <= next_cnt;
      vlow_timed        <= next_vlow_timed;
      session_active    <= next_session;
      host_role         <= next_host;
      request_busy      <= next_busy;
      request_done      <= next_done;
      request_seen      <= next_seen;
      dp_pulldown_en    <= next_pd_dp;
      dm_pulldown_en    <= next_pd_dm;
      dp_pullup_en      <= next_pu_dp;
      vbus_drive_en     <= next_vdrv;
      vbus_discharge_en <= next_vdis;
    end
  end

  // helper counters watched only by the checks below
  logic [CW-1:0] disch_len, pulse_len;
  always_ff @(posedge clk) begin
    if (srst) begin
      disch_len <= '0;
      pulse_len <= '0;
    end else begin
      disch_len <= vbus_discharge_en ? disch_len + CW'(1) : '0;
      // cleared between pulses so each request is measured on its own
      pulse_len <= (state == ST_DPULSE) ? pulse_len + CW'(1) : '0;
    end
  end

  sequence s_pulse_ends;
    (state == ST_DPULSE) ##1 (state != ST_DPULSE);
  endsequence
  sequence s_pulse_starts;
    (state != ST_DPULSE) ##1 (state == ST_DPULSE);
  endsequence

  a_session_b_side: assert property (@(posedge clk) disable iff (srst)
    (!is_a && bvld_s) |=> session_active) else $error("b session not tracked");
  a_host_default: assert property (@(posedge clk) disable iff (srst)
    $rose(session_active) |-> host_role == $past(is_a)) else $error("wrong start role");
  a_session_a_end: assert property (@(posedge clk) disable iff (srst)
    (is_a && !avld_s) |=> !session_active) else $error("a session outlived vbus");
  a_both_methods: assert property (@(posedge clk) disable iff (srst)
    s_pulse_ends |-> vbus_drive_en && !$past(vbus_drive_en)) else $error("no vbus pulse");
  a_vbus_low_first: assert property (@(posedge clk) disable iff (srst)
    s_pulse_starts |-> $past(vbus_low, 1)) else $error("pulse before vbus low");
  a_se0_before_pulse: assert property (@(posedge clk) disable iff (srst)
    s_pulse_starts |-> $past(se0_tif.done) && $past(!dp_s && !dm_s))
    else $error("pulse without idle lines");
  a_discharge_limit: assert property (@(posedge clk) disable iff (srst)
    disch_len <= CW'(DISCH_CYC)) else $error("discharge held too long");
  a_idle_pulldowns: assert property (@(posedge clk) disable iff (srst)
    (state == ST_IDLE && !next_session) |=> dp_pulldown_en && dm_pulldown_en)
    else $error("idle pulldowns off");
  a_periph_terms: assert property (@(posedge clk) disable iff (srst)
    (next_session && !next_host && !packet_tx) |=> !dp_pulldown_en && dm_pulldown_en
    && dp_pullup_en) else $error("peripheral terminations wrong");
  a_release_in_tx: assert property (@(posedge clk) disable iff (srst)
    (!dm_pulldown_en || (session_active && !host_role && !dp_pullup_en))
    |-> $past(packet_tx)) else $error("termination dropped outside tx");
  a_pulse_length: assert property (@(posedge clk) disable iff (srst)
    s_pulse_ends |-> pulse_len >= CW'(DPLS_MIN) && pulse_len <= CW'(DPLS_MAX))
    else $error("data pulse length out of range");
  a_order: assert property (@(posedge clk) disable iff (srst)
    $rose(vbus_drive_en) |-> $past(state == ST_DPULSE)) else $error("vbus pulse first");
endmodule // sesreq_ctrl

// File: verification/sesreq_far_model.sv
// Purpose: far device across the cable, VBUS charge and data line levels
// Assumes: one clock; vbus kept as 0 below end, 1 stale, 2 valid
// Notes:   stale charge leaves only through the discharge path
`timescale 1ns/100ps
module sesreq_far_model (
  input  wire logic clk,
  input  wire logic a_drive,
  input  wire logic far_pullup,
  input  wire logic dm_glitch,
  input  wire logic pullup_en,
  input  wire logic pulse_en,
  input  wire logic disch_en,
  output logic      dp,
  output logic      dm,
  output logic      a_vld,
  output logic      b_vld,
  output logic      b_end
);
  int lvl = 0;
  int dis = 0;
  // a lazy request that skips discharge never sees vbus fall on its own
  always @(posedge clk) begin
    dis <= disch_en ? dis + 1 : 0;
    if (a_drive)
      lvl <= 2;
    else if (pulse_en || lvl == 2)
      lvl <= 1;
    else if (dis >= 15)
      lvl <= 0;
  end
  // pulled-down lines read low unless someone pulls up
  assign dp    = pullup_en | far_pullup;
  assign dm    = dm_glitch;
  assign a_vld = (lvl == 2);
  assign b_vld = (lvl == 2);
  assign b_end = (lvl == 0);
endmodule // sesreq_far_model

// File: verification/testbench.sv
// Purpose: self-checking bench for the session request control block
// Assumes: shortened counts given to the design as parameters
// Notes:   every wait is bounded and a timeout ends the run
`timescale 1ns/100ps
module testbench;
  localparam int SE0 = 20, DPLS = 30, DPMIN = 25, DPMAX = 40, DISCH = 50, VPLS = 10;
  localparam int SA = 0, HR = 1, SN = 4, PU = 7, VD = 8, DC = 9;
  logic clk, srst, id_a_side, request_start, use_discharge, timed_discharge;
  logic a_vbus_on, role_swap, packet_tx, a_drive, far_pullup, dm_glitch;
  wire  dp_line, dm_line, a_vld, b_vld, b_end;
  wire  session_active, host_role, request_busy, request_done, request_seen;
  wire  dp_pulldown_en, dm_pulldown_en, dp_pullup_en, vbus_drive_en, vbus_discharge_en;
  wire  [9:0] o;
  int   fail_count = 0;
  int   tests_run = 0;
  assign o = {vbus_discharge_en, vbus_drive_en, dp_pullup_en, dm_pulldown_en,
              dp_pulldown_en, request_seen, request_done, request_busy, host_role,
              session_active};
  sesreq_ctrl #(.SE0_CYC(SE0), .DPLS_CYC(DPLS), .DPLS_MIN(DPMIN), .DPLS_MAX(DPMAX),
                .DISCH_CYC(DISCH), .VPLS_CYC(VPLS)) DUT (
    .clk(clk), .srst(srst), .id_a_side(id_a_side), .dp_line(dp_line),
    .dm_line(dm_line), .a_sess_valid_cmp(a_vld), .b_sess_valid_cmp(b_vld),
    .b_sess_end_cmp(b_end), .request_start(request_start),
    .use_discharge(use_discharge), .timed_discharge(timed_discharge),
    .a_vbus_on(a_vbus_on), .role_swap(role_swap), .packet_tx(packet_tx),
    .session_active(session_active), .host_role(host_role),
    .request_busy(request_busy), .request_done(request_done),
    .request_seen(request_seen), .dp_pulldown_en(dp_pulldown_en),
    .dm_pulldown_en(dm_pulldown_en), .dp_pullup_en(dp_pullup_en),
    .vbus_drive_en(vbus_drive_en), .vbus_discharge_en(vbus_discharge_en));
  sesreq_far_model far (
    .clk(clk), .a_drive(a_drive), .far_pullup(far_pullup), .dm_glitch(dm_glitch),
    .pullup_en(dp_pullup_en), .pulse_en(vbus_drive_en), .disch_en(vbus_discharge_en),
    .dp(dp_line), .dm(dm_line), .a_vld(a_vld), .b_vld(b_vld), .b_end(b_end));

  // inputs change 1 ns after the edge so no race with the design's flops
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    tests_run++;
    if (g != e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // counts cycles until output bit i shows v; running out ends the run
  task automatic wt(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (o[i] !== v && n < lim) begin
      cy(1);
      n++;
    end
    chk(o[i], v);
    if (o[i] !== v)
      stop_test();
  endtask
  // one whole request as B; the shape of the pulses is judged as it runs
  task automatic run_req(input logic dis, input logic tmd, input logic glitch);
    int n;
    use_discharge = dis;
    timed_discharge = tmd;
    request_start = 1;
    cy(1);
    request_start = 0;
    chk(request_busy, 1);
    if (dis) begin
      wt(DC, 1, 5, n);
      wt(DC, 0, 60, n);
      if (tmd)
        chkn(n, DISCH);
      else // model drains 16 cycles after enable, then 2 sync flops and 1 output flop
        chkn(n, 15 + 4);
    end
    if (glitch) begin
      cy(5);
      dm_glitch = 1;
      cy(1);
      dm_glitch = 0;
    end
    wt(PU, 1, 100, n);
    if (glitch)
      chk(n >= SE0, 1);
    chk(b_end, 1);
    chk(dp_pulldown_en, 0);
    chk(vbus_drive_en, 0);
    wt(PU, 0, 50, n);
    chkn(n, DPLS);
    chk(vbus_drive_en, 1);
    wt(VD, 0, 20, n);
    chkn(n, VPLS);
    chk(request_done, 1);
    chk(request_busy, 0);
    cy(1);
    chk(request_done, 0);
  endtask
  task automatic t_reset;
    chk(session_active, 0);
    chk(dp_pulldown_en, 1);
    chk(dm_pulldown_en, 1);
    chk(dp_pullup_en, 0);
    $display("test reset done");
  endtask
  task automatic t_plain;
    run_req(0, 0, 1);
    $display("test plain request done");
  endtask
  task automatic t_disch;
    run_req(1, 0, 0);
    $display("test comparator discharge done");
  endtask
  task automatic t_timed;
    run_req(1, 1, 0);
    $display("test timed discharge done");
  endtask
  // reset lands in the first cycle of a data-line pulse; terminations must fall back at once
  task automatic t_midrst;
    int n;
    use_discharge = 1;
    timed_discharge = 0;
    request_start = 1;
    cy(1);
    request_start = 0;
    wt(PU, 1, 100, n);
    srst = 1;
    cy(1);
    chk(dp_pullup_en, 0);
    chk(dp_pulldown_en, 1);
    chk(request_busy, 0);
    srst = 0;
    cy(1);
    chk(request_busy, 0);
    chk(vbus_drive_en, 0);
    $display("test mid-run reset done");
  endtask
  task automatic t_bsess;
    int n;
    a_drive = 1;
    wt(SA, 1, 8, n);
    cy(1);
    chk(host_role, 0);
    chk(dp_pulldown_en, 0);
    chk(dm_pulldown_en, 1);
    chk(dp_pullup_en, 1);
    request_start = 1;
    cy(1);
    request_start = 0;
    cy(1);
    chk(request_busy, 0);
    packet_tx = 1;
    cy(2);
    chk(dm_pulldown_en, 0);
    chk(dp_pullup_en, 0);
    packet_tx = 0;
    cy(2);
    chk(dp_pullup_en, 1);
    role_swap = 1;
    cy(1);
    role_swap = 0;
    cy(1);
    chk(host_role, 1);
    chk(dp_pulldown_en, 1);
    chk(dp_pullup_en, 0);
    a_drive = 0;
    wt(SA, 0, 8, n);
    chk(host_role, 0);
    $display("test b session done");
  endtask
  task automatic t_aside;
    int n;
    id_a_side = 1;
    cy(4);
    request_start = 1;
    cy(1);
    request_start = 0;
    cy(1);
    chk(request_busy, 0);
    far_pullup = 1;
    wt(SN, 1, 8, n);
    cy(1);
    chk(request_seen, 0);
    far_pullup = 0;
    dm_glitch = 1;
    wt(SN, 1, 8, n);
    cy(1);
    chk(request_seen, 0);
    dm_glitch = 0;
    a_vbus_on = 1;
    a_drive = 1;
    wt(SA, 1, 8, n);
    chk(request_seen, 0);
    chk(host_role, 1);
    a_drive = 0;
    wt(SA, 0, 8, n);
    a_vbus_on = 0;
    a_drive = 1;
    wt(SN, 1, 8, n);
    chk(session_active, 1);
    a_drive = 0;
    wt(SA, 0, 8, n);
    $display("test a side done");
  endtask

  // free-running 25 MHz clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // reset, then the scenarios in an order that leaves vbus stale for discharge
  initial begin
    {srst, id_a_side, request_start, use_discharge, timed_discharge} = 5'h10;
    {a_vbus_on, role_swap, packet_tx, a_drive, far_pullup, dm_glitch} = 6'h00;
    cy(16);
    srst = 0;
    cy(1);
    t_reset;
    t_plain;
    t_disch;
    t_timed;
    t_midrst;
    t_bsess;
    t_aside;
    stop_test();
  end
endmodule // testbench
